// ---- hw/cvsr_consts.vh ----
/*
 * Constants of the charger status and input voltage floor register bank:
 * register indices, field positions, reset values and interrupt bit layout.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef CVSR_CONSTS_VH
`define CVSR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CVSR_IDX_W            6
`define CVSR_IDX_SRC_STATUS   6'h0B
`define CVSR_IDX_FAULT        6'h0C
`define CVSR_IDX_FLOOR        6'h0D
`define CVSR_IDX_ILIM         6'h30
`define CVSR_IDX_IRQ_STATUS   6'h31
`define CVSR_IDX_IRQ_MASK     6'h32

// ----------------------------------------------------------------------------
// Source and charge status fields
// ----------------------------------------------------------------------------
`define CVSR_SRC_NONE         3'h0
`define CVSR_SRC_OTG          3'h7
`define CVSR_PHASE_IDLE       2'h0
`define CVSR_PHASE_PRE        2'h1
`define CVSR_PHASE_FAST       2'h2
`define CVSR_PHASE_DONE       2'h3

// ----------------------------------------------------------------------------
// Fault status fields
// ----------------------------------------------------------------------------
`define CVSR_CHG_OK           2'h0
`define CVSR_CHG_INPUT        2'h1
`define CVSR_CHG_THERMAL      2'h2
`define CVSR_CHG_TIMER        2'h3
`define CVSR_NTC_NORMAL       3'h0
`define CVSR_NTC_COLD         3'h1
`define CVSR_NTC_HOT          3'h2

// ----------------------------------------------------------------------------
// Input voltage floor register
// ----------------------------------------------------------------------------
`define CVSR_FLOOR_SEL_BIT    7
`define CVSR_FLOOR_SEL_RST    1'h0
`define CVSR_FLOOR_RST        7'h12
`define CVSR_FLOOR_MIN        7'h0D

// ----------------------------------------------------------------------------
// Input current limit register
// ----------------------------------------------------------------------------
`define CVSR_ILIM_W           6
`define CVSR_ILIM_RST         6'h00

// ----------------------------------------------------------------------------
// Interrupt status and mask layout
// ----------------------------------------------------------------------------
`define CVSR_IRQ_W            3
`define CVSR_IRQ_STATUS_CHG   0
`define CVSR_IRQ_FAULT_SET    1
`define CVSR_IRQ_PLUG_IN      2
`define CVSR_IRQ_MASK_RST     3'h0

`endif

// ---- hw/cvsr_floor.v ----
/*
 * Input voltage floor control: method select bit, stored floor code and the
 * clamped floor that the regulation loop uses.
 * Assumes one clock, a synchronous active-high reset and one-cycle strobes.
 */
`timescale 1ns/1ps
`include "cvsr_consts.vh"

module cvsr_floor (
   // Clock and reset
   input  wire       clock,
   input  wire       srst,
   // Host write
   input  wire       host_wr,
   input  wire [7:0] host_wdata,
   // Internal control
   input  wire       plug_in,
   input  wire       rel_update,
   input  wire [6:0] rel_floor,
   // State
   output reg        select_reg,
   output reg  [6:0] floor_reg,
   output reg  [6:0] applied_reg
);

   // ----------------------------------------------------------------------------
   // Floor storage
   // ----------------------------------------------------------------------------
   reg       select_next;
   reg [6:0] floor_next;

   always @* begin
      select_next = select_reg;
      floor_next  = floor_reg;
      if (plug_in) begin
         select_next = `CVSR_FLOOR_SEL_RST;                 // R12
         floor_next  = `CVSR_FLOOR_RST;                     // R12
      end else if (host_wr) begin
         select_next = host_wdata[`CVSR_FLOOR_SEL_BIT];     // R11
         if (host_wdata[`CVSR_FLOOR_SEL_BIT]) begin
            floor_next = host_wdata[6:0];                   // R16
         end
      end else if (rel_update && !select_reg) begin
         floor_next = rel_floor;                            // R15
      end
   end

   // Clamping after storage keeps the readback equal to what was written.
   always @(posedge clock) begin
      if (srst) begin
         select_reg  <= `CVSR_FLOOR_SEL_RST;
         floor_reg   <= `CVSR_FLOOR_RST;                     // R13
         applied_reg <= `CVSR_FLOOR_RST;
      end else begin
         select_reg  <= select_next;
         floor_reg   <= floor_next;
         applied_reg <= (floor_next < `CVSR_FLOOR_MIN) ? `CVSR_FLOOR_MIN : floor_next; // R14
      end
   end

endmodule // cvsr_floor

// ---- hw/cvsr_irq.v ----
/*
 * Sticky interrupt status with write-one-to-clear, a mask register and one
 * level interrupt output.
 * Assumes one clock, a synchronous active-high reset and one-cycle strobes.
 */
`timescale 1ns/1ps
`include "cvsr_consts.vh"

module cvsr_irq (
   // Clock and reset
   input  wire                   clock,
   input  wire                   srst,
   // Events
   input  wire [`CVSR_IRQ_W-1:0] events,
   // Host writes
   input  wire                   clr_wr,
   input  wire                   mask_wr,
   input  wire [`CVSR_IRQ_W-1:0] wdata,
   // State
   output reg  [`CVSR_IRQ_W-1:0] status_reg,
   output reg  [`CVSR_IRQ_W-1:0] mask_reg,
   output reg                    irq_reg
);

   // ----------------------------------------------------------------------------
   // Status and mask
   // ----------------------------------------------------------------------------
   wire [`CVSR_IRQ_W-1:0] clr_bits;
   wire [`CVSR_IRQ_W-1:0] status_next;
   wire [`CVSR_IRQ_W-1:0] mask_next;

   // A new event in the clearing cycle survives the clear.
   assign clr_bits    = clr_wr ? wdata : {`CVSR_IRQ_W{1'b0}};
   assign status_next = (status_reg & ~clr_bits) | events;
   assign mask_next   = mask_wr ? wdata : mask_reg;

   always @(posedge clock) begin
      if (srst) begin
         status_reg <= {`CVSR_IRQ_W{1'b0}};
         mask_reg   <= `CVSR_IRQ_MASK_RST;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         mask_reg   <= mask_next;
         irq_reg    <= |(status_next & mask_next);
      end
   end

endmodule // cvsr_irq

// ---- hw/cvsr_regs.v ----
/*
 * Charger status and input voltage floor register bank behind an APB slave.
 * Holds the source and charge status, the fault status, the input voltage
 * floor control, the input current limit and the interrupt registers.
 * Assumes the analogue side presents its conditions as levels synchronous to
 * clock, plug-in and update requests as one-cycle pulses, and an APB master.
 */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "cvsr_consts.vh"

// Functional notes
// R1: Bits 7:5 of source status show the detected input source code.
// R2: Current limit chosen for the detected source is loaded into its register.
// R3: Bits 4:3 of source status show the charge phase.
// R4: Bit 2 of source status is one while input power is good.
// R5: Bit 0 is one while the system rail sits in minimum-voltage regulation.
// R6: Bit 7 of fault status is one after the host watchdog expired.
// R7: Bit 6 of fault status reports supply-mode overload, overvoltage or low battery.
// R8: Bits 5:4 of fault status encode the charge fault.
// R9: Bit 3 of fault status is one during battery overvoltage.
// R10: Bits 2:0 of fault status report the thermistor state.
// R11: Floor register bit 7 selects relative (0) or absolute (1) floor method.
// R12: A plugged-in source returns method bit and floor field to defaults.
// R13: Floor code is 2.6V plus 100mV per step; default code 0x12.
// R14: Floor codes below 0x0D are applied as 0x0D.
// R15: With method bit 0 the floor field follows internal control, host cannot write.
// R16: With method bit 1 the host writes the floor field, which is applied.
// R17: Writes to both status registers are ignored; they show live conditions.
// R18: Bit 1 of source status reads as zero.
module cvsr_regs (
   // Clock and reset
   input  wire        clock,
   input  wire        srst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Source and charge conditions
   input  wire [2:0]  input_source_type,
   input  wire [1:0]  charge_phase,
   input  wire        power_good_flag,
   input  wire        min_system_reg_flag,
   // Fault conditions
   input  wire        watchdog_expired,
   input  wire        supply_overload,
   input  wire        supply_overvoltage,
   input  wire        supply_battery_low,
   input  wire [1:0]  charge_fault_code,
   input  wire        battery_overvoltage_fault,
   input  wire [2:0]  thermistor_fault_code,
   // Input detection
   input  wire        source_plug_in,
   input  wire        limit_valid,
   input  wire [5:0]  limit_code,
   // Relative floor from internal control
   input  wire        rel_floor_update,
   input  wire [6:0]  rel_floor_code,
   // Regulation outputs
   output wire        abs_floor_select,
   output wire [6:0]  input_voltage_floor,
   output reg  [5:0]  input_current_limit,
   // Interrupt
   output wire        irq
);

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   function [31:0] cvsr_word;
      input [7:0] value;
      begin
         cvsr_word = {24'h000000, value};
      end
   endfunction

   function cvsr_hit;
      input [5:0] idx;
      input [5:0] want;
      begin
         cvsr_hit = (idx == want);
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Live status capture
   // ----------------------------------------------------------------------------
   reg  [7:0] src_status_reg;
   reg  [7:0] fault_status_reg;
   reg  [7:0] src_status_prev_reg;
   reg  [7:0] fault_status_prev_reg;
   reg        status_valid_reg;
   wire [7:0] src_status_next;
   wire [7:0] fault_status_next;
   wire       supply_fault;

   assign supply_fault = supply_overload | supply_overvoltage | supply_battery_low; // R7

   assign src_status_next = {input_source_type,    // R1
                             charge_phase,         // R3
                             power_good_flag,      // R4
                             1'b0,                 // R18
                             min_system_reg_flag}; // R5

   assign fault_status_next = {watchdog_expired,          // R6
                               supply_fault,              // R7
                               charge_fault_code,         // R8
                               battery_overvoltage_fault, // R9
                               thermistor_fault_code};    // R10

   // Status is resampled every cycle, so host writes never reach it.
   always @(posedge clock) begin
      if (srst) begin
         src_status_reg        <= 8'h00;
         fault_status_reg      <= 8'h00;
         src_status_prev_reg   <= 8'h00;
         fault_status_prev_reg <= 8'h00;
         status_valid_reg      <= 1'b0;
      end else begin
         src_status_reg        <= src_status_next;   // R17
         fault_status_reg      <= fault_status_next; // R17
         src_status_prev_reg   <= src_status_reg;
         fault_status_prev_reg <= fault_status_reg;
         status_valid_reg      <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt events
   // ----------------------------------------------------------------------------
   reg                    status_seen_reg;
   wire [`CVSR_IRQ_W-1:0] irq_events;
   wire                   status_changed;
   wire                   fault_rose;

   // The first sample after reset is not compared, to avoid a spurious event.
   always @(posedge clock) begin
      if (srst) begin
         status_seen_reg <= 1'b0;
      end else begin
         status_seen_reg <= status_valid_reg;
      end
   end

   assign status_changed = status_seen_reg && (src_status_reg != src_status_prev_reg);
   assign fault_rose     = status_seen_reg &&
                           (fault_status_reg != fault_status_prev_reg) &&
                           (fault_status_reg != 8'h00);

   assign irq_events[`CVSR_IRQ_STATUS_CHG] = status_changed;
   assign irq_events[`CVSR_IRQ_FAULT_SET]  = fault_rose;
   assign irq_events[`CVSR_IRQ_PLUG_IN]    = source_plug_in;

   // ----------------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------------
   reg         pready_reg;
   wire [5:0]  idx;
   wire        aligned;
   wire        mapped;
   wire        access_first;
   wire        access_done;
   wire        wr_done;
   wire        wr_floor;
   wire        wr_ilim;
   wire        wr_irq_clr;
   wire        wr_irq_mask;

   assign idx     = paddr[7:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign mapped  = aligned &&
                    (cvsr_hit(idx, `CVSR_IDX_SRC_STATUS) ||
                     cvsr_hit(idx, `CVSR_IDX_FAULT) ||
                     cvsr_hit(idx, `CVSR_IDX_FLOOR) ||
                     cvsr_hit(idx, `CVSR_IDX_ILIM) ||
                     cvsr_hit(idx, `CVSR_IDX_IRQ_STATUS) ||
                     cvsr_hit(idx, `CVSR_IDX_IRQ_MASK));

   // One wait state: the answer is prepared in the first access cycle.
   assign access_first = psel && penable && !pready_reg;
   assign access_done  = psel && penable && pready_reg;
   assign wr_done      = access_done && pwrite && mapped;

   assign wr_floor    = wr_done && cvsr_hit(idx, `CVSR_IDX_FLOOR);
   assign wr_ilim     = wr_done && cvsr_hit(idx, `CVSR_IDX_ILIM);
   assign wr_irq_clr  = wr_done && cvsr_hit(idx, `CVSR_IDX_IRQ_STATUS);
   assign wr_irq_mask = wr_done && cvsr_hit(idx, `CVSR_IDX_IRQ_MASK);

   // ----------------------------------------------------------------------------
   // Input voltage floor
   // ----------------------------------------------------------------------------
   wire       floor_select;
   wire [6:0] floor_code;
   wire [6:0] floor_applied;

   cvsr_floor u_floor (
      .clock       (clock),
      .srst        (srst),
      .host_wr     (wr_floor),          // R16
      .host_wdata  (pwdata[7:0]),
      .plug_in     (source_plug_in),    // R12
      .rel_update  (rel_floor_update),  // R15
      .rel_floor   (rel_floor_code),
      .select_reg  (floor_select),
      .floor_reg   (floor_code),
      .applied_reg (floor_applied)
   );

   assign abs_floor_select    = floor_select;
   assign input_voltage_floor = floor_applied;

   // ----------------------------------------------------------------------------
   // Input current limit
   // ----------------------------------------------------------------------------
   // A fresh detection result wins over a host write in the same cycle.
   always @(posedge clock) begin
      if (srst) begin
         input_current_limit <= `CVSR_ILIM_RST;
      end else if (limit_valid) begin
         input_current_limit <= limit_code; // R2
      end else if (wr_ilim) begin
         input_current_limit <= pwdata[`CVSR_ILIM_W-1:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt registers
   // ----------------------------------------------------------------------------
   wire [`CVSR_IRQ_W-1:0] irq_status;
   wire [`CVSR_IRQ_W-1:0] irq_mask;

   cvsr_irq u_irq (
      .clock      (clock),
      .srst       (srst),
      .events     (irq_events),
      .clr_wr     (wr_irq_clr),
      .mask_wr    (wr_irq_mask),
      .wdata      (pwdata[`CVSR_IRQ_W-1:0]),
      .status_reg (irq_status),
      .mask_reg   (irq_mask),
      .irq_reg    (irq)
   );

   // ----------------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------------
   reg [31:0] rdata_next;

   always @* begin
      rdata_next = 32'h00000000;
      case (idx)
         `CVSR_IDX_SRC_STATUS: begin
            rdata_next = cvsr_word(src_status_reg); // R18
         end
         `CVSR_IDX_FAULT: begin
            rdata_next = cvsr_word(fault_status_reg);
         end
         `CVSR_IDX_FLOOR: begin
            rdata_next = cvsr_word({floor_select, floor_code}); // R11
         end
         `CVSR_IDX_ILIM: begin
            rdata_next = cvsr_word({2'h0, input_current_limit}); // R2
         end
         `CVSR_IDX_IRQ_STATUS: begin
            rdata_next = cvsr_word({5'h00, irq_status});
         end
         `CVSR_IDX_IRQ_MASK: begin
            rdata_next = cvsr_word({5'h00, irq_mask});
         end
         default: begin
            rdata_next = 32'h00000000;
         end
      endcase
      if (!aligned) begin
         rdata_next = 32'h00000000;
      end
   end

   // ----------------------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------------------
   // Read data is held until the next answer is prepared; the error flag clears once the answer is taken.
   always @(posedge clock) begin
      if (srst) begin
         pready_reg <= 1'b0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h00000000;
      end else begin
         pready_reg <= access_first;
         pready     <= access_first;
         if (access_first) begin
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h00000000 : rdata_next;
         end else if (access_done) begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule // cvsr_regs

// ---- tb/cvsr_regs_asserts.sv ----
/* Checker for cvsr_regs: APB answer timing, floor control, current limit
   and interrupt clearing. Assumes it is bound to cvsr_regs and that the
   master keeps APB order with an idle cycle between transfers. */
`timescale 1ns/1ps

module cvsr_asserts (
   // Clock and reset
   input wire        clock,
   input wire        srst,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Detection and control
   input wire        source_plug_in,
   input wire        limit_valid,
   input wire [5:0]  limit_code,
   input wire        rel_floor_update,
   input wire [6:0]  rel_floor_code,
   // Outputs
   input wire        abs_floor_select,
   input wire [6:0]  input_voltage_floor,
   input wire [5:0]  input_current_limit,
   input wire        irq
);
   // A write lands at the edge where pready is seen, so that edge is the cause.
   wire       fl_wr  = psel && penable && pready && pwrite && (paddr == 8'h34);
   wire [6:0] wr_cl  = (pwdata[6:0] < 7'h0D) ? 7'h0D : pwdata[6:0];
   wire [6:0] rel_cl = (rel_floor_code < 7'h0D) ? 7'h0D : rel_floor_code;

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("answer not after exactly one wait state");
   err_addr_a: assert property (pready && (paddr[1:0] != 2'h0) |-> pslverr)
      else $error("unaligned access without error");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   rsvd_bit_a: assert property (pready && !pwrite && paddr == 8'h2C |-> !prdata[1])
      else $error("reserved status bit reads one");
   clamp_min_a: assert property (input_voltage_floor >= 7'h0D)
      else $error("applied floor below minimum code");
   plug_default_a: assert property (source_plug_in |=> !abs_floor_select && input_voltage_floor == 7'h12)
      else $error("plug-in did not restore floor defaults");
   rel_follow_a: assert property (rel_floor_update && !abs_floor_select && !source_plug_in && !fl_wr
      |=> input_voltage_floor == $past(rel_cl)) else $error("relative floor not applied");
   abs_write_a: assert property (fl_wr && pwdata[7] && !source_plug_in
      |=> abs_floor_select && input_voltage_floor == $past(wr_cl)) else $error("absolute floor write not applied");
   select_hold_a: assert property (!$stable(abs_floor_select) && !$past(srst)
      |-> $past(source_plug_in || fl_wr)) else $error("method bit changed without cause");
   limit_load_a: assert property (limit_valid |=> input_current_limit == $past(limit_code))
      else $error("detected current limit not loaded");
   irq_clear_a: assert property ($fell(irq) && !$past(srst) |-> $past(psel && penable && pready && pwrite))
      else $error("interrupt dropped without a host write");

   cover property (fl_wr && pwdata[7]);
   cover property (source_plug_in && abs_floor_select);
   cover property ($fell(irq));
endmodule // cvsr_asserts

bind cvsr_regs cvsr_asserts cvsr_asserts_u (
   .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .source_plug_in(source_plug_in), .limit_valid(limit_valid), .limit_code(limit_code),
   .rel_floor_update(rel_floor_update), .rel_floor_code(rel_floor_code),
   .abs_floor_select(abs_floor_select), .input_voltage_floor(input_voltage_floor),
   .input_current_limit(input_current_limit), .irq(irq)
);

// ---- tb/cvsr_regs_test.sv ----
/* Self-checking bench for cvsr_regs: status, floor, limit, interrupt and
   error scenarios over APB. Assumes the design files under hw/. */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end

module cvsr_regs_test;
   logic        clock, srst, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rnd;
   wire  [31:0] prdata;
   wire         pready, pslverr, abs_floor_select, irq;
   wire  [6:0]  input_voltage_floor;
   wire  [5:0]  input_current_limit;
   logic [2:0]  src, ntc;
   logic [1:0]  phase, chg;
   logic        pg, minsys, wd, s_ol, s_ov, s_bl, bat, plug, lim_v, rel_u;
   logic [5:0]  lim;
   logic [6:0]  rel, code;
   logic [6:0]  tbl [3] = '{7'h0C, 7'h0D, 7'h7F};
   logic [32:0] expq [$];
   logic [32:0] exp_v;
   integer      seed = 32'hf664645a;
   integer      fail_count = 0;
   integer      check_count = 0;
   integer      i;

   cvsr_regs dut_u (
      .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_source_type(src), .charge_phase(phase), .power_good_flag(pg),
      .min_system_reg_flag(minsys), .watchdog_expired(wd), .supply_overload(s_ol),
      .supply_overvoltage(s_ov), .supply_battery_low(s_bl), .charge_fault_code(chg),
      .battery_overvoltage_fault(bat), .thermistor_fault_code(ntc), .source_plug_in(plug),
      .limit_valid(lim_v), .limit_code(lim), .rel_floor_update(rel_u), .rel_floor_code(rel),
      .abs_floor_select(abs_floor_select), .input_voltage_floor(input_voltage_floor),
      .input_current_limit(input_current_limit), .irq(irq)
   );

   // ------------------------------------------------------------------
   // Clock, run end and bus tasks
   // ------------------------------------------------------------------
   always #50 clock = ~clock;

   task conclude;
      // A note still queued means an answer never arrived, which counts as a mismatch.
      if (expq.size() != 0) fail_count++;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task tick(input integer n);
      repeat (n) @(posedge clock);
   endtask

   // The expected answer is queued before the request so the monitor owns every bus answer compare.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      integer n;
      expq.push_back(e);
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clock);
      if (n == 20) begin
         fail_count++;
         conclude;
      end
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, {25'h0, e});
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, 33'h0);
   endtask

   // Writes are judged on the error flag only; prdata reads zero after a write.
   always @(posedge clock) if (psel && penable && pready) begin
      if (expq.size() == 0) `CHK(1'b0, 1'b1)
      else begin
         exp_v = expq.pop_front();
         `CHK(pslverr, exp_v[32])
         if (!pwrite) `CHK(prdata, exp_v[31:0])
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      clock = 1'b0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      {src, ntc, phase, chg, pg, minsys, wd, s_ol, s_ov, s_bl, bat} = '0;
      {plug, lim_v, rel_u, lim, rel} = '0;
      tick(5);
      srst <= 1'b0;
      rd(8'h34, 8'h12);
      `CHK(abs_floor_select, 1'b0)
      `CHK(input_voltage_floor, 7'h12)
      rd(8'hC8, 8'h00);
      for (i = 0; i < 8; i++) begin
         rnd = $random(seed);
         src <= i[2:0]; phase <= i[1:0]; chg <= i[1:0]; ntc <= 3'(i % 3);
         {pg, minsys, wd, s_ol, s_ov, s_bl, bat} <= rnd[6:0];
         tick(3);
         wr(8'h2C, 8'hFF);
         wr(8'h30, 8'hFF);
         rd(8'h2C, {src, phase, pg, 1'b0, minsys});
         rd(8'h30, {wd, s_ol | s_ov | s_bl, chg, bat, ntc});
      end
      wr(8'h34, 8'h05);
      rd(8'h34, 8'h12);
      rel <= 7'h08; rel_u <= 1'b1;
      tick(1);
      rel_u <= 1'b0;
      tick(1);
      `CHK(input_voltage_floor, 7'h0D)
      rd(8'h34, 8'h08);
      for (i = 0; i < 4; i++) begin
         rnd = $random(seed);
         code = (i == 3) ? rnd[6:0] : tbl[i];
         wr(8'h34, {1'b1, code});
         tick(1);
         `CHK(abs_floor_select, 1'b1)
         `CHK(input_voltage_floor, (code < 7'h0D) ? 7'h0D : code)
         rd(8'h34, {1'b1, code});
      end
      rel_u <= 1'b1;
      tick(1);
      rel_u <= 1'b0;
      rd(8'h34, {1'b1, code});
      rd(8'hC4, 8'h03);
      `CHK(irq, 1'b0)
      wr(8'hC8, 8'h07);
      tick(1);
      `CHK(irq, 1'b1)
      wr(8'hC4, 8'h07);
      tick(1);
      `CHK(irq, 1'b0)
      wr(8'hC8, 8'h04);
      plug <= 1'b1;
      tick(1);
      plug <= 1'b0;
      tick(1);
      `CHK(irq, 1'b1)
      `CHK(abs_floor_select, 1'b0)
      `CHK(input_voltage_floor, 7'h12)
      rd(8'h34, 8'h12);
      rd(8'hC4, 8'h04);
      wr(8'hC4, 8'h04);
      rnd = $random(seed);
      lim <= rnd[5:0]; lim_v <= 1'b1;
      tick(1);
      lim_v <= 1'b0;
      tick(1);
      `CHK(input_current_limit, lim)
      `CHK(irq, 1'b0)
      rd(8'hC0, {2'h0, lim});
      wr(8'hC0, 8'h15);
      rd(8'hC0, 8'h15);
      apb(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0});
      apb(1'b0, 8'h2D, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 8'hFC, 32'h1, {1'b1, 32'h0});
      tick(2);
      conclude;
   end
endmodule // cvsr_regs_test
